// file: verification/spm_serial_a_pm_tb_top.sv
// self-checking testbench for the serial port a power management block
module spm_serial_a_pm_tb_top
   import spm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   //------------------------------------------------------------------
   // signals and design under test
   //------------------------------------------------------------------
   localparam int TO = 8;  // short timeout for simulation

   logic       mclk;      // chip clock
   logic       arst_n;    // hard reset pin
   logic [7:0] reg_addr;  // register index
   logic [7:0] reg_wdata; // write data
   logic       reg_wr;    // write strobe
   logic       reg_rd;    // read strobe
   logic [7:0] reg_rdata; // read data
   logic       tx_fifo_empty, rx_fifo_empty, tx_active, rx_active;  // datapath status
   logic       divisor_latch_access_bit, baud_clock, uart_sout;     // serial sources
   logic       serial_output_pin, port_module_reset, txrx_reset;    // port control
   logic       direct_powerdown, auto_powerdown, irq;               // modes and interrupt
   int         error_cnt;  // mismatches
   int         tests_run;  // comparisons
   logic [7:0] rd;         // last read value

   spm_serial_a_pm #(.TIMEOUT_CYC(TO)) i_dut (
      .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_fifo_empty(tx_fifo_empty), .rx_fifo_empty(rx_fifo_empty),
      .tx_active(tx_active), .rx_active(rx_active),
      .divisor_latch_access_bit(divisor_latch_access_bit), .baud_clock(baud_clock),
      .uart_sout(uart_sout), .serial_output_pin(serial_output_pin),
      .port_module_reset(port_module_reset), .txrx_reset(txrx_reset),
      .direct_powerdown(direct_powerdown), .auto_powerdown(auto_powerdown), .irq(irq));

   // ordinary register cases: written value, read back, modes
   typedef struct {
      logic [7:0] wdata;  // value written to the power register
      logic [7:0] rdata;  // value read back
      logic       dpd;    // expected direct powerdown
      logic       mrst;   // expected module reset
   } spm_row_s;
   spm_row_s rows [7] = '{'{8'he3, 8'h01, 1'b1, 1'b0}, '{8'h00, 8'h00, 1'b0, 1'b0},
                          '{8'h10, 8'h10, 1'b0, 1'b0}, '{8'h08, 8'h08, 1'b0, 1'b0},
                          '{8'h01, 8'h01, 1'b1, 1'b0}, '{8'h05, 8'h04, 1'b0, 1'b1},
                          '{8'h00, 8'h00, 1'b0, 1'b0}};

   // clock of 20 ns
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   //------------------------------------------------------------------
   // helper tasks
   //------------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask : wr

   // one-cycle read strobe, data taken in the following cycle only
   task automatic rdr(input logic [7:0] a);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask : rdr

   // compare and count
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // verdict and end of run
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim

   // poll the idle flag with a bounded count
   task automatic wait_idle();
      for (int k = 0; k < 4 * TO; k++) begin
         rdr(SPM_CFG_IDX);
         if (rd[SPM_BIT_IDLE] === 1'b1) return;
      end
      error_cnt++;
      $display("[FAIL] idle flag expected 1 seen %b", rd[SPM_BIT_IDLE]);
      end_sim();
   endtask : wait_idle

   //------------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------------
   initial begin
      error_cnt = 0;
      tests_run = 0;
      arst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_fifo_empty = 1'b1;
      rx_fifo_empty = 1'b1;
      tx_active = 1'b1;  // keeps the timeout from expiring
      rx_active = 1'b0;
      divisor_latch_access_bit = 1'b0;
      baud_clock = 1'b0;
      uart_sout = 1'b0;
      cyc(4);
      chk("pin in reset", 8'h01, serial_output_pin);
      chk("module reset in reset", 8'h01, port_module_reset);
      @(posedge mclk);
      arst_n <= 1'b1;
      cyc(3);
      // unmapped write first, then reset values and the unmapped index
      wr(8'h30, 8'hff);
      rdr(SPM_CFG_IDX);
      chk("cfg reset", 8'h00, rd);
      rdr(SPM_STAT_IDX);
      chk("stat reset", 8'h00, rd);
      rdr(SPM_MASK_IDX);
      chk("mask reset", 8'h00, rd);
      rdr(8'h30);
      chk("unmapped", 8'h00, rd);
      $display("test reset values done");

      // table of ordinary writes
      foreach (rows[i]) begin
         wr(SPM_CFG_IDX, rows[i].wdata);
         cyc(rows[i].wdata[SPM_BIT_SRST] ? SPM_SRST_MIN_CYC : 1);
         rdr(SPM_CFG_IDX);
         chk("cfg readback", rows[i].rdata, rd);
         chk("direct pd", 8'(rows[i].dpd), direct_powerdown);
         chk("module reset", 8'(rows[i].mrst), port_module_reset);
         chk("txrx reset", 8'(rows[i].dpd | rows[i].mrst), txrx_reset);
      end
      $display("test register table done");

      // test mode: baud clock only while latch bit is also set
      wr(SPM_CFG_IDX, 8'h10);
      for (int m = 0; m < 2; m++) begin
         @(posedge mclk);
         divisor_latch_access_bit <= (m == 0);
         uart_sout                <= (m == 1);
         cyc(2);
         repeat (6) begin
            @(posedge mclk);
            baud_clock <= ~baud_clock;
            #1;
            chk("serial pin", (m == 0) ? {7'h00, ~baud_clock} : 8'h01, serial_output_pin);
         end
      end
      $display("test baud clock output done");

      // one fifo not empty: no idle, no auto powerdown
      wr(SPM_CFG_IDX, 8'h08);
      tx_active <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         tx_fifo_empty <= (k == 1);
         rx_fifo_empty <= (k == 0);
         cyc(3 * TO);
         rdr(SPM_CFG_IDX);
         chk("idle with data", 8'h08, rd);
         chk("auto pd with data", 8'h00, auto_powerdown);
      end
      $display("test fifo not empty done");

      // idle without auto powerdown, masked then unmasked event
      wr(SPM_CFG_IDX, 8'h00);
      tx_fifo_empty <= 1'b1;
      rx_fifo_empty <= 1'b1;
      wait_idle();
      chk("auto pd disabled", 8'h00, auto_powerdown);
      chk("irq masked", 8'h00, irq);
      rdr(SPM_STAT_IDX);
      chk("idle event", 8'h01, rd);
      wr(SPM_MASK_IDX, 8'h03);
      cyc(1);
      chk("irq unmasked", 8'h01, irq);
      wr(SPM_STAT_IDX, 8'h01);
      cyc(1);
      chk("irq cleared", 8'h00, irq);
      $display("test idle interrupt done");

      // auto powerdown once enabled while idle
      wr(SPM_CFG_IDX, 8'h08);
      cyc(2);
      chk("auto pd enabled", 8'h01, auto_powerdown);
      rdr(SPM_STAT_IDX);
      chk("auto pd event", 8'h02, rd);
      chk("irq auto pd", 8'h01, irq);
      cyc(1);
      chk("read data dropped", 8'h00, reg_rdata);
      wr(SPM_STAT_IDX, 8'h02);
      $display("test auto powerdown done");

      // direct powerdown keeps the idle flag despite activity
      wr(SPM_CFG_IDX, 8'h01);
      tx_active <= 1'b1;
      cyc(2);
      chk("txrx reset in dpd", 8'h01, txrx_reset);
      chk("auto pd in dpd", 8'h00, auto_powerdown);
      rdr(SPM_CFG_IDX);
      chk("idle frozen", 8'h03, rd);
      wr(SPM_CFG_IDX, 8'h00);
      cyc(1);
      rdr(SPM_CFG_IDX);
      chk("idle cleared", 8'h00, rd);
      $display("test direct powerdown done");

      // soft reset clears a set idle flag and direct powerdown
      @(posedge mclk);
      tx_active <= 1'b0;
      wait_idle();
      wr(SPM_CFG_IDX, 8'h01);
      wr(SPM_CFG_IDX, 8'h05);
      cyc(SPM_SRST_MIN_CYC);
      rdr(SPM_CFG_IDX);
      chk("soft reset cfg", 8'h04, rd);
      chk("soft reset port", 8'h01, port_module_reset);
      chk("soft reset dpd", 8'h00, direct_powerdown);
      wr(SPM_CFG_IDX, 8'h00);
      cyc(1);
      chk("soft reset end", 8'h00, port_module_reset);
      $display("test soft reset done");

      // hard reset in mid run: idle first, then direct powerdown holds it
      wr(SPM_CFG_IDX, 8'h18);
      wait_idle();
      wr(SPM_CFG_IDX, 8'h19);
      @(posedge mclk);
      arst_n <= 1'b0;
      cyc(1);
      chk("hard reset port", 8'h01, port_module_reset);
      chk("hard reset dpd", 8'h00, direct_powerdown);
      chk("hard reset auto pd", 8'h00, auto_powerdown);
      chk("hard reset irq", 8'h00, irq);
      chk("hard reset pin", 8'h01, serial_output_pin);
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      cyc(3);
      rdr(SPM_CFG_IDX);
      chk("cfg after hard reset", 8'h00, rd);
      rdr(SPM_MASK_IDX);
      chk("mask after hard reset", 8'h00, rd);
      $display("test hard reset done");
      end_sim();
   end

endmodule : spm_serial_a_pm_tb_top

// file: verilog/spm_idle_timer.sv
// inactivity timeout counter of the serial port
module spm_idle_timer
   import spm_pkg::*;
#(
   parameter int TIMEOUT_CYC = SPM_TIMEOUT_CYC  // idle cycles to expiry
) (
   // clock and reset
   input  logic mclk,      // chip clock
   input  logic srst_n,    // synchronised reset
   // control
   input  logic restart,   // activity or module reset
   // status
   output logic expired    // timeout reached
);

   localparam int CW = $clog2(TIMEOUT_CYC + 1);  // counter width

   typedef struct packed {
      logic [CW-1:0] cnt;  // idle cycles seen
      logic          exp;  // expired flag
   } spm_tmr_s;

   spm_tmr_s st;       // state
   spm_tmr_s next_st;  // next state

   // count idle cycles, restart on activity
   always_comb begin
      next_st = st;
      if (restart) begin
         next_st.cnt = '0;  // [R17]
         next_st.exp = 1'b0;
      end else if (!st.exp) begin
         next_st.cnt = st.cnt + 1'b1;
         next_st.exp = (st.cnt == CW'(TIMEOUT_CYC - 1));  // [R17]
      end
   end

   // register state
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign expired = st.exp;

endmodule : spm_idle_timer

// file: verilog/spm_pkg.sv
// constants and types for the serial port a power management block
//------------------------------------------------------------------
// Function
// [R1] test bit plus latch bit drives baud clock out
// [R2] auto powerdown only while its enable is set
// [R3] auto powerdown needs empty fifos and timeout
// [R4] module reset bit holds the port in reset
// [R5] soft reset equals hard reset state
// [R6] software holds reset bit at least 1.13 us
// [R7] idle flag set on empty fifos and timeout
// [R8] idle flag cleared when port not idle
// [R9] direct powerdown leaves idle flag unchanged
// [R10] idle flag is read only
// [R11] hard reset forces idle flag to zero
// [R12] direct powerdown bit enters and leaves powerdown
// [R13] module reset bit also ends direct powerdown
// [R14] direct powerdown resets transmitter, receiver, fifos
// [R15] software checks idle before direct powerdown
// [R16] control bits reset to zero, reserved read zero
// [R17] timeout restarts on activity, expires after count
//------------------------------------------------------------------
package spm_pkg;

   // register indices
   localparam logic [7:0] SPM_CFG_IDX   = 8'h31;  // power management and status
   localparam logic [7:0] SPM_STAT_IDX  = 8'h32;  // sticky event status
   localparam logic [7:0] SPM_MASK_IDX  = 8'h33;  // event interrupt mask

   // field positions of the power management register
   localparam int SPM_BIT_TEST = 4;  // baud clock test enable
   localparam int SPM_BIT_APD  = 3;  // auto powerdown enable
   localparam int SPM_BIT_SRST = 2;  // module soft reset
   localparam int SPM_BIT_IDLE = 1;  // port idle flag
   localparam int SPM_BIT_DPD  = 0;  // direct powerdown

   // event bits of status and mask
   localparam int SPM_EVT_W    = 2;  // number of events
   localparam int SPM_EVT_IDLE = 0;  // port became idle
   localparam int SPM_EVT_APD  = 1;  // auto powerdown entered

   // reset values
   localparam logic                 SPM_CTRL_RST = 1'b0;  // control bits
   localparam logic [SPM_EVT_W-1:0] SPM_EVT_RST  = 2'h0;  // status and mask

   // timing
   localparam int  SPM_CLK_MHZ      = 50;     // mclk rate
   localparam real SPM_SRST_MIN_US  = 1.13;   // least soft reset pulse
   localparam int  SPM_SRST_MIN_CYC = int'($ceil(SPM_SRST_MIN_US * SPM_CLK_MHZ));
   localparam int  SPM_TIMEOUT_CYC  = 1024;   // idle cycles before expiry

   // power mode of the port
   typedef enum logic [1:0] {
      SPM_PM_ACTIVE = 2'b00,  // running
      SPM_PM_AUTO   = 2'b01,  // auto powerdown
      SPM_PM_DIRECT = 2'b10,  // direct powerdown
      SPM_PM_RESET  = 2'b11   // held in module reset
   } spm_pm_e;

   // idle condition, shared by flag and auto powerdown
   function automatic logic spm_idle_cond(input logic tx_empty,
                                          input logic rx_empty,
                                          input logic expired);
      spm_idle_cond = tx_empty & rx_empty & expired;
   endfunction : spm_idle_cond

endpackage : spm_pkg

// file: verilog/spm_rst_sync.sv
// reset release synchroniser for the power management block
module spm_rst_sync
   import spm_pkg::*;
(
   // clock and reset
   input  logic mclk,     // chip clock
   input  logic arst_n,   // hard reset, async
   // synchronised reset
   output logic srst_n    // released two edges late
);

   typedef struct packed {
      logic s1;  // first stage
      logic s2;  // second stage
   } spm_rsync_s;

   spm_rsync_s st;       // state
   spm_rsync_s next_st;  // next state

   // shift a one in after release
   always_comb begin
      next_st    = st;
      next_st.s1 = 1'b1;
      next_st.s2 = st.s1;
   end

   // assert at once, release on clock
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign srst_n = st.s2;

endmodule : spm_rst_sync

// file: verilog/spm_serial_a_pm.sv
// power management and status control of serial port a
//
// Local design decision: the address-and-strobe port.
module spm_serial_a_pm
   import spm_pkg::*;
#(
   parameter int TIMEOUT_CYC = SPM_TIMEOUT_CYC  // idle cycles to expiry
) (
   // clock and hard reset
   input  logic       mclk,                      // chip clock
   input  logic       arst_n,                    // hard reset pin, low
   // register port
   input  logic [7:0] reg_addr,                  // register index
   input  logic [7:0] reg_wdata,                 // write data
   input  logic       reg_wr,                    // write strobe
   input  logic       reg_rd,                    // read strobe
   output logic [7:0] reg_rdata,                 // read data, next cycle
   // serial port datapath status
   input  logic       tx_fifo_empty,             // transmit fifo empty
   input  logic       rx_fifo_empty,             // receive fifo empty
   input  logic       tx_active,                 // transmit activity
   input  logic       rx_active,                 // receive activity
   input  logic       divisor_latch_access_bit,  // from line control register
   input  logic       baud_clock,                // baud generator output
   input  logic       uart_sout,                 // normal serial data
   // serial pin and port control
   output logic       serial_output_pin,         // serial output pin
   output logic       port_module_reset,         // whole port reset
   output logic       txrx_reset,                // transmitter, receiver, fifo reset
   output logic       direct_powerdown,          // direct powerdown mode
   output logic       auto_powerdown,            // auto powerdown mode
   // interrupt
   output logic       irq                        // level, unmasked event
);

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   typedef struct packed {
      logic                 test_en;   // baud clock test enable
      logic                 apd_en;    // auto powerdown enable
      logic                 soft_rst;  // module soft reset
      logic                 idle;      // port idle flag
      logic                 dpd;       // direct powerdown
      logic [SPM_EVT_W-1:0] evt_stat;  // sticky events
      logic [SPM_EVT_W-1:0] evt_mask;  // event mask
      logic [7:0]           rdata;     // read answer
      logic                 sout;      // registered pin value
      spm_pm_e              pm;        // power mode
   } spm_top_s;

   spm_top_s st;       // state
   spm_top_s next_st;  // next state

   logic srst_n;      // synchronised hard reset
   logic expired;     // inactivity timeout reached
   logic idle_now;    // fifos empty and timed out
   logic apd_go;      // auto powerdown condition
   logic cfg_wr;      // write to power register
   logic [SPM_EVT_W-1:0] evt_set;  // events this cycle
   logic [SPM_EVT_W-1:0] evt_clr;  // write one to clear
   spm_pm_e pm_now;   // mode from current bits

   //------------------------------------------------------------
   // submodules
   //------------------------------------------------------------
   spm_rst_sync u_rst (
      .mclk   (mclk),
      .arst_n (arst_n),
      .srst_n (srst_n)
   );

   // timer restarts with activity and with module reset
   spm_idle_timer #(
      .TIMEOUT_CYC (TIMEOUT_CYC)
   ) u_tmr (
      .mclk    (mclk),
      .srst_n  (srst_n),
      .restart (tx_active | rx_active | port_module_reset),
      .expired (expired)
   );

   //------------------------------------------------------------
   // port controls
   //------------------------------------------------------------
   // soft reset drives the same line as hard reset
   assign port_module_reset = ~srst_n | st.soft_rst;  // [R4] [R5]
   // direct powerdown flushes transmitter, receiver, fifos
   assign txrx_reset        = st.dpd | port_module_reset;  // [R14]
   assign direct_powerdown  = st.dpd;
   assign auto_powerdown    = (st.pm == SPM_PM_AUTO);
   assign serial_output_pin = st.sout;
   assign reg_rdata         = st.rdata;
   assign irq               = |(st.evt_stat & st.evt_mask);

   //------------------------------------------------------------
   // decode
   //------------------------------------------------------------
   assign idle_now = spm_idle_cond(tx_fifo_empty, rx_fifo_empty, expired);  // [R3] [R7]
   assign apd_go   = st.apd_en & idle_now & ~st.dpd & ~port_module_reset;  // [R2] [R3]
   assign cfg_wr   = reg_wr & (reg_addr == SPM_CFG_IDX);
   assign evt_clr  = (reg_wr && reg_addr == SPM_STAT_IDX) ? reg_wdata[SPM_EVT_W-1:0] : '0;

   // mode that the current bits select
   always_comb begin
      if (port_module_reset) begin
         pm_now = SPM_PM_RESET;
      end else if (st.dpd) begin
         pm_now = SPM_PM_DIRECT;
      end else if (apd_go) begin
         pm_now = SPM_PM_AUTO;
      end else begin
         pm_now = SPM_PM_ACTIVE;
      end
   end

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      next_st       = st;
      next_st.rdata = 8'h00;
      evt_set       = '0;
      // control bits, idle bit ignored on write
      if (cfg_wr) begin
         next_st.test_en  = reg_wdata[SPM_BIT_TEST];
         next_st.apd_en   = reg_wdata[SPM_BIT_APD];
         next_st.soft_rst = reg_wdata[SPM_BIT_SRST];  // [R4]
         next_st.dpd      = reg_wdata[SPM_BIT_DPD];   // [R12]
         if (reg_wdata[SPM_BIT_SRST]) begin
            next_st.dpd = 1'b0;  // [R13]
         end
      end
      // idle flag, hardware only
      if (port_module_reset) begin
         next_st.idle = 1'b0;  // [R11] [R5]
      end else if (st.dpd) begin
         next_st.idle = st.idle;  // [R9]
      end else begin
         next_st.idle = idle_now;  // [R7] [R8] [R10]
      end
      // power mode and entry events
      next_st.pm = pm_now;
      case (st.pm)
         SPM_PM_AUTO: begin
            evt_set[SPM_EVT_APD] = 1'b0;  // already inside
         end
         SPM_PM_ACTIVE, SPM_PM_DIRECT, SPM_PM_RESET: begin
            evt_set[SPM_EVT_APD] = (pm_now == SPM_PM_AUTO);
         end
         default: begin
            evt_set[SPM_EVT_APD] = 1'b0;
         end
      endcase
      evt_set[SPM_EVT_IDLE] = next_st.idle & ~st.idle;
      // set wins over clear
      next_st.evt_stat = (st.evt_stat & ~evt_clr) | evt_set;
      if (reg_wr && reg_addr == SPM_MASK_IDX) begin
         next_st.evt_mask = reg_wdata[SPM_EVT_W-1:0];
      end
      // read answer, reserved bits zero
      if (reg_rd) begin
         case (reg_addr)
            SPM_CFG_IDX: begin
               next_st.rdata = {3'h0, st.test_en, st.apd_en, st.soft_rst, st.idle, st.dpd};
            end
            SPM_STAT_IDX: begin
               next_st.rdata = {{(8-SPM_EVT_W){1'b0}}, st.evt_stat};
            end
            SPM_MASK_IDX: begin
               next_st.rdata = {{(8-SPM_EVT_W){1'b0}}, st.evt_mask};
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
      // test mode with the latch bit set puts baud clock on the pin
      if (st.test_en && divisor_latch_access_bit) begin
         next_st.sout = baud_clock;  // [R1]
      end else begin
         next_st.sout = uart_sout;
      end
   end

   //------------------------------------------------------------
   // state register
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         st          <= '0;
         st.test_en  <= SPM_CTRL_RST;  // [R16]
         st.apd_en   <= SPM_CTRL_RST;
         st.soft_rst <= SPM_CTRL_RST;
         st.dpd      <= SPM_CTRL_RST;
         st.idle     <= 1'b0;  // [R11]
         st.evt_stat <= SPM_EVT_RST;
         st.evt_mask <= SPM_EVT_RST;
         st.sout     <= 1'b1;  // line idles high
         st.pm       <= SPM_PM_RESET;
      end else begin
         st <= next_st;
      end
   end

   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!srst_n);

   sequence soft_set_s;
      cfg_wr && reg_wdata[SPM_BIT_SRST];
   endsequence

   sequence dpd_set_s;
      cfg_wr && reg_wdata[SPM_BIT_DPD] && !reg_wdata[SPM_BIT_SRST];
   endsequence

   sequence idle_cond_s;
      idle_now && !st.dpd && !port_module_reset;
   endsequence

   // baud clock reaches the pin one cycle later
   test_pin_a: assert property ( // [R1]
      (st.test_en && divisor_latch_access_bit) |=> serial_output_pin == $past(baud_clock))
      else $error("baud clock not on serial output in test mode");

   // no auto powerdown while disabled
   apd_off_a: assert property ( // [R2]
      !st.apd_en |=> !auto_powerdown || $past(st.apd_en))
      else $error("auto powerdown while disabled");

   // auto powerdown only with empty fifos and timeout
   apd_cond_a: assert property ( // [R3]
      auto_powerdown |-> $past(tx_fifo_empty && rx_fifo_empty && expired))
      else $error("auto powerdown without idle conditions");

   // soft reset bit holds the port in reset
   soft_hold_a: assert property ( // [R4]
      soft_set_s |=> port_module_reset && !direct_powerdown ##1 st.pm == SPM_PM_RESET)
      else $error("soft reset did not hold the port");

   // soft reset clears idle just like hard reset
   soft_like_a: assert property ( // [R5]
      port_module_reset |=> !st.idle)
      else $error("idle flag survived module reset");

   // idle flag follows the conditions
   idle_set_a: assert property ( // [R7]
      idle_cond_s |=> st.idle)
      else $error("idle flag not set");

   // idle flag drops when not idle
   idle_clr_a: assert property ( // [R8]
      (!idle_now && !st.dpd) |=> !st.idle)
      else $error("idle flag not cleared");

   // direct powerdown freezes the idle flag
   dpd_freeze_a: assert property ( // [R9]
      (st.dpd && !port_module_reset) |=> $stable(st.idle))
      else $error("idle flag changed in direct powerdown");

   // writing the idle bit has no effect
   idle_ro_a: assert property ( // [R10]
      (cfg_wr && reg_wdata[SPM_BIT_IDLE] && !idle_now && !st.dpd) |=> !st.idle)
      else $error("idle flag written by software");

   // release of hard reset shows zero control bits
   reset_val_a: assert property ( // [R11]
      $rose(srst_n) |-> !st.idle && !st.test_en && !st.apd_en && !st.soft_rst && !st.dpd)
      else $error("bad reset values");

   // direct powerdown bit enters the mode and flushes
   dpd_enter_a: assert property ( // [R12]
      dpd_set_s |=> direct_powerdown && txrx_reset ##1 st.pm == SPM_PM_DIRECT || !direct_powerdown)
      else $error("direct powerdown not entered");

   // soft reset ends direct powerdown
   soft_dpd_a: assert property ( // [R13]
      (direct_powerdown ##0 soft_set_s) |=> !direct_powerdown)
      else $error("soft reset left direct powerdown");

   // flush held for the whole of direct powerdown
   dpd_flush_a: assert property ( // [R14]
      direct_powerdown |-> txrx_reset)
      else $error("fifos not flushed in direct powerdown");

   // clearing the direct powerdown bit leaves the mode
   dpd_exit_a: assert property ( // [R12]
      (cfg_wr && !reg_wdata[SPM_BIT_DPD]) |=> !direct_powerdown)
      else $error("direct powerdown not left");

   // clearing the enable ends auto powerdown, mode register lags one cycle
   apd_exit_a: assert property ( // [R2]
      (cfg_wr && !reg_wdata[SPM_BIT_APD]) |-> ##2 !auto_powerdown)
      else $error("auto powerdown kept after disable");

   // read answer stands only in the next cycle
   rd_answer_a: assert property ( // [R16]
      (reg_rd && reg_addr == SPM_CFG_IDX) |=> reg_rdata[7:5] == 3'h0 &&
         reg_rdata[SPM_BIT_IDLE] == $past(st.idle))
      else $error("bad power register read");

endmodule : spm_serial_a_pm
